// File: pkg/ebm_pkg.sv
// shared types and constants for the embedded block memory
// assumes a single fabric clock; port clocks arrive as sampled levels
package ebm_pkg;
  localparam int unsigned TOTAL_BITS    = 4096;
  localparam int unsigned ROWS          = 256;
  localparam int unsigned ROW_W         = 16;
  localparam int unsigned ROW_AW        = 8;
  localparam int unsigned MAX_AW        = 11;
  localparam logic [15:0] RDATA_RST     = 16'h0000;
  localparam logic [1:0]  SYNC_RST      = 2'h0;
  localparam logic        STAGE_RST     = 1'h0;
  localparam logic        LEVEL_RST     = 1'h0;
  localparam logic        FLAG_RST      = 1'h0;

  // aspect ratio; encoding value is log2 of the depth increase
  typedef enum logic [1:0] {
    EBM_SHAPE_256X16,
    EBM_SHAPE_512X8,
    EBM_SHAPE_1024X4,
    EBM_SHAPE_2048X2
  } ebm_shape_t;

  typedef struct packed {
    logic [MAX_AW-1:0] addr;
    logic [ROW_W-1:0]  data;
    logic [ROW_W-1:0]  mask;  // 1 = keep old bit, 256x16 only
    logic              en;
  } ebm_wr_req_t;

  typedef struct packed {
    logic [MAX_AW-1:0] addr;
    logic              en;
  } ebm_rd_req_t;
endpackage

// File: rtl/ebm_block_mem.sv
// embedded block memory: 4 kbit synchronous ram, four aspect ratios,
// separate write and read ports with selectable active clock edge.
// assumes port clocks are slow levels from the fabric, oversampled by i_clk;
// address, data, mask and enables stay stable until the edge is taken.
`timescale 1ns/100ps

// port clock qualifier: three-stage sampling, change accepted when stages 2 and 3 agree
module ebm_edge (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_port_clk,
  input  wire logic i_neg_sel,
  output logic      o_fire
);
  logic [1:0] pipe_reg;
  logic [1:0] pipe_next;
  logic       s3_reg;
  logic       s3_next;
  logic       level_reg;
  logic       level_next;
  logic       fire_reg;
  logic       fire_next;

  // three flops cost three cycles per port edge but stop a pin moving near i_clk from firing twice
  // next state; first stage feeds only the second
  always_comb begin
    pipe_next  = {pipe_reg[0], i_port_clk};
    s3_next    = pipe_reg[1];
    level_next = level_reg;
    fire_next  = 1'b0;
    if (pipe_reg[1] == s3_reg && s3_reg != level_reg) begin
      level_next = s3_reg;
      fire_next  = (s3_reg == ~i_neg_sel);
    end
  end

  // registers only; the sampler starts low, so an idle-high port clock
  // shows one rise after reset, which fires the port in rising-edge mode and is ignored in falling-edge mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pipe_reg  <= ebm_pkg::SYNC_RST;
      s3_reg    <= ebm_pkg::STAGE_RST;
      level_reg <= ebm_pkg::LEVEL_RST;
      fire_reg  <= ebm_pkg::FLAG_RST;
    end else begin
      pipe_reg  <= pipe_next;
      s3_reg    <= s3_next;
      level_reg <= level_next;
      fire_reg  <= fire_next;
    end
  end

  assign o_fire = fire_reg;
endmodule

// Function
// - each block stores exactly 4 kbit
// - single, pseudo dual-port or fifo storage use
// - 256x16 uses 8-bit addresses, 16-bit mask
// - 512x8 uses 9-bit addresses, no mask
// - 1024x4 uses 10-bit addresses, no mask
// - 2048x2 uses 11-bit addresses, no mask
// - each port clock edge independently selectable
module ebm_block_mem (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire ebm_pkg::ebm_shape_t  i_shape,
  input  wire logic                 i_wclk,
  input  wire logic                 i_wclk_neg,
  input  wire ebm_pkg::ebm_wr_req_t i_wr,
  input  wire logic                 i_rclk,
  input  wire logic                 i_rclk_neg,
  input  wire ebm_pkg::ebm_rd_req_t i_rd,
  output logic [15:0]               o_rdata,
  output logic                      o_rvalid
);
  logic [ebm_pkg::ROW_W-1:0] mem [ebm_pkg::ROWS];
  logic                      wr_edge;
  logic                      rd_edge;
  logic                      wr_fire;
  logic                      rd_fire;
  logic [1:0]                sh;
  logic [ebm_pkg::ROW_W-1:0] lane_ones;
  logic [3:0]                wr_off;
  logic [3:0]                rd_off;
  logic [ebm_pkg::ROW_AW-1:0] wr_row;
  logic [ebm_pkg::ROW_AW-1:0] rd_row;
  logic [ebm_pkg::ROW_W-1:0] wr_bits;
  logic [ebm_pkg::ROW_W-1:0] wr_word;
  logic [ebm_pkg::ROW_W-1:0] row_new;
  logic [ebm_pkg::ROW_W-1:0] rd_word;
  logic [15:0]               rdata_reg;
  logic [15:0]               rdata_next;
  logic                      rvalid_reg;
  logic                      rvalid_next;

  // one sampler per port, each with its own polarity select
  ebm_edge u_wr_edge (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_port_clk (i_wclk),
    .i_neg_sel  (i_wclk_neg),
    .o_fire     (wr_edge)
  );

  ebm_edge u_rd_edge (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_port_clk (i_rclk),
    .i_neg_sel  (i_rclk_neg),
    .o_fire     (rd_edge)
  );

  assign sh      = i_shape;
  assign wr_fire = wr_edge && i_wr.en;
  assign rd_fire = rd_edge && i_rd.en;

  // address split: row from the upper bits, lane from the low sh bits
  // narrow lanes pack side by side in one 16-bit row, so every shape shares one store
  always_comb begin
    lane_ones = 16'hFFFF >> (5'h10 - (5'h10 >> sh));
    wr_row    = 8'((i_wr.addr >> sh) & 11'h0FF);
    rd_row    = 8'((i_rd.addr >> sh) & 11'h0FF);
    wr_off    = 4'((i_wr.addr & ((11'h001 << sh) - 11'h001)) << (3'h4 - 3'(sh)));
    rd_off    = 4'((i_rd.addr & ((11'h001 << sh) - 11'h001)) << (3'h4 - 3'(sh)));
    wr_bits   = lane_ones << wr_off;
    // mask only exists in the widest shape; narrow shapes ignore it
    if (i_shape == ebm_pkg::EBM_SHAPE_256X16) begin
      wr_bits = wr_bits & ~i_wr.mask;
    end
    wr_word = (i_wr.data & lane_ones) << wr_off;
    row_new = (mem[wr_row] & ~wr_bits) | (wr_word & wr_bits);
    rd_word = (mem[rd_row] >> rd_off) & lane_ones;
  end

  // memory array: no reset, contents undefined until written
  always_ff @(posedge i_clk) begin
    if (wr_fire) begin
      mem[wr_row] <= row_new;
    end
  end

  // read-first on a shared row: no bypass mux, shorter read path
  // read port; same-cycle read of the written row returns old data
  always_comb begin
    rdata_next  = rd_fire ? rd_word : rdata_reg;
    rvalid_next = rd_fire;
  end

  // output registers; rdata holds between reads
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_reg  <= ebm_pkg::RDATA_RST;
      rvalid_reg <= ebm_pkg::FLAG_RST;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_rdata  = rdata_reg;
  assign o_rvalid = rvalid_reg;

  // checks
  a_total_bits: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (32'(ebm_pkg::ROWS) * 32'(ebm_pkg::ROW_W)) == 32'(ebm_pkg::TOTAL_BITS))
    else $error("capacity is not 4 kbit");
  a_read_before_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_fire && wr_fire |=> o_rdata == $past(rd_word))
    else $error("simultaneous read lost old data");
  a_mask_keeps_bits: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_fire && i_shape == ebm_pkg::EBM_SHAPE_256X16
    |=> ((mem[$past(wr_row)] ^ $past(mem[wr_row])) & $past(i_wr.mask)) == 16'h0000)
    else $error("masked bit changed");
  a_narrow_512_top: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_fire && i_shape == ebm_pkg::EBM_SHAPE_512X8 |=> o_rdata[15:8] == 8'h00)
    else $error("512x8 read wider than 8 bits");
  a_narrow_1024_top: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_fire && i_shape == ebm_pkg::EBM_SHAPE_1024X4 |=> o_rdata[15:4] == 12'h000)
    else $error("1024x4 read wider than 4 bits");
  a_narrow_2048_top: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_fire && i_shape == ebm_pkg::EBM_SHAPE_2048X2 |=> o_rdata[15:2] == 14'h0000)
    else $error("2048x2 read wider than 2 bits");
  a_edge_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rclk) && i_rclk_neg ##1 i_rclk [*4] |-> !rd_edge [*4])
    else $error("rising edge taken in falling mode");
  a_read_latency: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_fire |=> o_rvalid && o_rdata == $past(rd_word))
    else $error("read data not presented next cycle");
  a_hold_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rd_fire |=> o_rdata == $past(o_rdata) && !o_rvalid)
    else $error("read data changed without read edge");
  // port polarity and a single fire per transition
  a_wr_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_wclk) && i_wclk_neg ##1 i_wclk [*4] |-> !wr_edge [*4])
    else $error("rising edge taken in falling write mode");
  a_rd_fire_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_edge |=> !rd_edge)
    else $error("read port fired twice for one transition");
  a_wr_fire_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_edge |=> !wr_edge)
    else $error("write port fired twice for one transition");
  // refused edges, and the data that lands
  a_read_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_edge && !i_rd.en |=> !o_rvalid && $stable(o_rdata))
    else $error("disabled read changed the output");
  a_write_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_edge && !i_wr.en |=> mem[$past(wr_row)] == $past(mem[wr_row]))
    else $error("disabled write changed the array");
  a_mask_writes_bits: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_fire && i_shape == ebm_pkg::EBM_SHAPE_256X16
    |=> ((mem[$past(wr_row)] ^ $past(i_wr.data)) & ~$past(i_wr.mask)) == 16'h0000)
    else $error("unmasked bit not written");
  a_narrow_lane_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_fire && i_shape != ebm_pkg::EBM_SHAPE_256X16
    |=> ((mem[$past(wr_row)] >> $past(wr_off)) & $past(lane_ones)) == ($past(i_wr.data) & $past(lane_ones)))
    else $error("narrow write did not land in its lane");

  c_write_256: cover property (@(posedge i_clk) wr_fire && i_shape == ebm_pkg::EBM_SHAPE_256X16);
  c_read_2048: cover property (@(posedge i_clk) rd_fire && i_shape == ebm_pkg::EBM_SHAPE_2048X2);
  c_both_ports: cover property (@(posedge i_clk) rd_fire && wr_fire && rd_row == wr_row);
  c_neg_write: cover property (@(posedge i_clk) wr_fire && i_wclk_neg);
  c_neg_read: cover property (@(posedge i_clk) rd_fire && i_rclk_neg);
endmodule

// File: test/ebm_block_mem_tb_top.sv
// bench: one write/read row per shape, then aliasing, mask, enable, edge, same-cycle and reset cases
// assumes the design package and the port driver model are compiled first
`timescale 1ns/100ps
module ebm_block_mem_tb_top;
  typedef struct packed {
    logic [1:0]  s;
    logic [10:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } ebm_row_t;
  ebm_row_t rows [4] = '{'{2'h0, 11'h0A5, 16'hBEEF, 16'hBEEF}, '{2'h1, 11'h1FF, 16'h1234, 16'h0034},
                         '{2'h2, 11'h3FE, 16'hABCD, 16'h000D}, '{2'h3, 11'h7FD, 16'hFFFE, 16'h0002}};
  logic                 i_clk   = 1'b0;
  logic                 i_rst_n = 1'b0;
  logic                 wn      = 1'b0;
  logic                 rn      = 1'b0;
  logic                 gw      = 1'b0;
  logic                 gr      = 1'b0;
  logic                 wclk, rclk, rvalid;
  logic [15:0]          rdata;
  ebm_pkg::ebm_shape_t  shape   = ebm_pkg::EBM_SHAPE_256X16;
  ebm_pkg::ebm_wr_req_t wr      = '0;
  ebm_pkg::ebm_rd_req_t rd      = '0;
  int                   n_mismatch = 0, checks = 0, cyc = 0, n_rv = 0;

  ebm_block_mem i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_shape(shape), .i_wclk(wclk), .i_wclk_neg(wn),
    .i_wr(wr), .i_rclk(rclk), .i_rclk_neg(rn), .i_rd(rd), .o_rdata(rdata), .o_rvalid(rvalid));
  ebm_port_driver i_wdrv (.i_clk(i_clk), .i_go(gw), .i_neg(wn), .o_pclk(wclk), .o_busy());
  ebm_port_driver i_rdrv (.i_clk(i_clk), .i_go(gr), .i_neg(rn), .o_pclk(rclk), .o_busy());

  always #10 i_clk = ~i_clk;

  // cycle ceiling and read-pulse count; the run needs well under 1000 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (rvalid === 1'b1) n_rv++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held from before the port edge until long after the fire cycle
  task automatic op(input logic w, input logic en, input logic [10:0] a, input logic [15:0] d,
                    input logic [15:0] m);
    @(posedge i_clk);
    wr <= '{a, d, m, w & en};
    rd <= '{a, ~w & en};
    gw <= w;
    gr <= ~w;
    @(posedge i_clk);
    gw <= 1'b0;
    gr <= 1'b0;
    repeat (9) @(posedge i_clk);
  endtask

  // write and read of one row, both port edges launched together
  task automatic op_both(input logic [10:0] a, input logic [15:0] d);
    @(posedge i_clk);
    wr <= '{a, d, 16'h0000, 1'b1};
    rd <= '{a, 1'b1};
    gw <= 1'b1;
    gr <= 1'b1;
    @(posedge i_clk);
    gw <= 1'b0;
    gr <= 1'b0;
    repeat (9) @(posedge i_clk);
  endtask

  task automatic complete_run();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    check(rdata, 16'h0000);
    foreach (rows[i]) begin
      @(posedge i_clk);
      shape <= ebm_pkg::ebm_shape_t'(rows[i].s);
      op(1'b1, 1'b1, rows[i].a, rows[i].d, 16'h0000);
      op(1'b0, 1'b1, rows[i].a, 16'h0000, 16'h0000);
      check(rdata, rows[i].e);
    end
    // one 2-bit lane lands in the top of a 16-bit row: same 4 kbit store
    shape <= ebm_pkg::EBM_SHAPE_256X16;
    op(1'b1, 1'b1, 11'h0FF, 16'h0000, 16'h0000);
    shape <= ebm_pkg::EBM_SHAPE_2048X2;
    op(1'b1, 1'b1, 11'h7FF, 16'h0003, 16'h0000);
    shape <= ebm_pkg::EBM_SHAPE_256X16;
    op(1'b0, 1'b1, 11'h0FF, 16'h0000, 16'h0000);
    check(rdata, 16'hC000);
    // mask bit set keeps the old bit
    op(1'b1, 1'b1, 11'h010, 16'hFFFF, 16'h0000);
    op(1'b1, 1'b1, 11'h010, 16'h0000, 16'h00FF);
    op(1'b0, 1'b1, 11'h010, 16'h0000, 16'h0000);
    check(rdata, 16'h00FF);
    // disabled write and disabled read leave row and output alone
    op(1'b1, 1'b0, 11'h010, 16'h1111, 16'h0000);
    op(1'b0, 1'b0, 11'h0A5, 16'h0000, 16'h0000);
    check(rdata, 16'h00FF);
    op(1'b0, 1'b1, 11'h010, 16'h0000, 16'h0000);
    check(rdata, 16'h00FF);
    // narrow shape ignores the mask
    shape <= ebm_pkg::EBM_SHAPE_512X8;
    op(1'b1, 1'b1, 11'h020, 16'h005A, 16'hFFFF);
    op(1'b0, 1'b1, 11'h020, 16'h0000, 16'h0000);
    check(rdata, 16'h005A);
    // falling-edge write with rising-edge read, ports set independently
    shape <= ebm_pkg::EBM_SHAPE_256X16;
    wn <= 1'b1;
    repeat (8) @(posedge i_clk);
    op(1'b1, 1'b1, 11'h030, 16'h5A5A, 16'h0000);
    op(1'b0, 1'b1, 11'h030, 16'h0000, 16'h0000);
    check(rdata, 16'h5A5A);
    check(n_rv[15:0], 16'h0009);
    // falling-edge read with rising-edge write: the other pairing of polarities
    wn <= 1'b0;
    rn <= 1'b1;
    repeat (8) @(posedge i_clk);
    op(1'b1, 1'b1, 11'h040, 16'hC3C3, 16'h0000);
    op(1'b0, 1'b1, 11'h040, 16'h0000, 16'h0000);
    check(rdata, 16'hC3C3);
    // write and read of one row in the same cycle: the read sees the old word
    op_both(11'h040, 16'h0F0F);
    check(rdata, 16'hC3C3);
    op(1'b0, 1'b1, 11'h040, 16'h0000, 16'h0000);
    check(rdata, 16'h0F0F);
    // reset in mid-run: outputs clear, stored words survive
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    check(rdata, ebm_pkg::RDATA_RST);
    check({15'h0000, rvalid}, 16'h0000);
    repeat (4) @(posedge i_clk);
    op(1'b0, 1'b1, 11'h040, 16'h0000, 16'h0000);
    check(rdata, 16'h0F0F);
    check(n_rv[15:0], 16'h000D);
    complete_run();
  end
endmodule

// File: test/ebm_port_driver.sv
// fabric-side port clock source: one active edge per request
// assumes i_go is a single-cycle pulse, issued only while o_busy is low
`timescale 1ns/100ps
module ebm_port_driver (
  input  wire logic i_clk,
  input  wire logic i_go,
  input  wire logic i_neg,
  output logic      o_pclk,
  output logic      o_busy
);
  logic [3:0] cnt_reg = 4'h0;

  // four cycles active, four idle: above the 2-cycle half-period floor
  always_ff @(posedge i_clk) begin
    if (i_go) begin
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  assign o_pclk = (cnt_reg > 4'h4) ? ~i_neg : i_neg; // idle level is the inactive one
  assign o_busy = (cnt_reg != 4'h0);
endmodule
